//--- core/clpt_defines.svh
// Purpose: offsets, field positions and reset values of the cascaded long-period timer
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: definitions only, included by the top module
`ifndef CLPT_DEFINES_SVH
`define CLPT_DEFINES_SVH

// register byte offsets
`define CLPT_OFF_CTRL 8'h00
`define CLPT_OFF_MODE0 8'h04
`define CLPT_OFF_MODE1 8'h08
`define CLPT_OFF_RELOAD0 8'h0C
`define CLPT_OFF_RELOAD1 8'h10
`define CLPT_OFF_COUNT0 8'h14
`define CLPT_OFF_COUNT1 8'h18
`define CLPT_OFF_EXTSEL 8'h1C
`define CLPT_OFF_PCLK 8'h20
`define CLPT_OFF_POL 8'h24
`define CLPT_OFF_STATUS 8'h28
`define CLPT_OFF_MASK 8'h2C

// field positions
`define CLPT_MODE_EVENT_BIT 0
`define CLPT_MODE_SRC_LO 6
`define CLPT_MODE_SRC_HI 7
`define CLPT_EXT_T0_LO 0
`define CLPT_EXT_T0_HI 3
`define CLPT_EXT_T1_LO 4
`define CLPT_EXT_T1_HI 7
`define CLPT_EXT_ENABLE_BIT 3

// reset values
`define CLPT_RST_CTRL 2'h0
`define CLPT_RST_MODE 8'h00
`define CLPT_RST_RELOAD 16'hFFFF
`define CLPT_RST_EXTSEL 8'h00
`define CLPT_RST_PCLK 1'h0
`define CLPT_RST_POL 2'h0
`define CLPT_RST_FLAGS 2'h0

// prescaler terminal counts
`define CLPT_DIV8_TC 3'h7
`define CLPT_DIV32_TC 5'h1F
`define CLPT_DIV64_TC 6'h3F

`endif

//--- core/clpt_pkg.sv
// Purpose: shared types of the cascaded long-period timer
// Assumes: nothing beyond the defines header
// Notes: carriers for count-source ticks and per-timer settings
package clpt_pkg;

  // one-cycle enables, one per candidate count source
  typedef struct packed {
    logic undiv;   // every clock
    logic half;    // every second clock
    logic div8;    // every eighth clock
    logic div32;   // every 32nd clock
    logic div64;   // every 64th clock
    logic oco;     // low-speed oscillator rising edge
    logic sub32;   // sub-clock divided by 32
  } clpt_ticks_type;

  // settings steering one timer
  typedef struct packed {
    logic start;       // count start flag
    logic event_mode;  // 1: event counter mode, 0: timer mode
    logic polarity;    // 1: inverted output
  } clpt_tcfg_type;

  // bus slave states, one-hot
  typedef enum logic [1:0] {
    CLPT_BUS_IDLE = 2'b01,
    CLPT_BUS_ACK = 2'b10
  } clpt_bus_state_type;

endpackage : clpt_pkg

//--- core/clpt_prescaler.sv
// Purpose: derive count-source tick enables from the system clock
// Assumes: SUB_CLK and LOCO inputs synchronous to clk
// Notes: all sources are enables, the block has a single clock
`timescale 1ns/100ps
`include "clpt_defines.svh"
module clpt_prescaler (
  input wire logic clk,
  input wire logic rst,
  input wire logic sub_clk,
  input wire logic loco,
  output clpt_pkg::clpt_ticks_type ticks
);
  import clpt_pkg::*;

  logic [5:0] div_reg;   // free-running divider
  logic [4:0] sub_reg;   // sub-clock edge divider
  logic sub_prev_reg;    // last sub-clock level
  logic loco_prev_reg;   // last oscillator level
  wire sub_rise = sub_clk & ~sub_prev_reg;
  wire loco_rise = loco & ~loco_prev_reg;

  // dividers run always so a source switch lands on a running phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= 6'h00;
      sub_reg <= 5'h00;
      sub_prev_reg <= 1'b0;
      loco_prev_reg <= 1'b0;
    end else begin
      div_reg <= div_reg + 6'h01;
      sub_prev_reg <= sub_clk;
      loco_prev_reg <= loco;
      if (sub_rise) begin
        sub_reg <= sub_reg + 5'h01;
      end
    end
  end

  // terminal counts give one-cycle ticks
  assign ticks.undiv = 1'b1;
  assign ticks.half = div_reg[0];
  assign ticks.div8 = (div_reg[2:0] == `CLPT_DIV8_TC);
  assign ticks.div32 = (div_reg[4:0] == `CLPT_DIV32_TC);
  assign ticks.div64 = (div_reg == `CLPT_DIV64_TC);
  assign ticks.oco = loco_rise;
  assign ticks.sub32 = sub_rise & (sub_reg == `CLPT_DIV32_TC);
endmodule : clpt_prescaler

//--- core/clpt_timer.sv
// Purpose: one 16-bit down counter with reload, underflow pulse and output pin
// Assumes: step enables are one cycle wide
// Notes: underflow is the step taken while the count is zero
`timescale 1ns/100ps
`include "clpt_defines.svh"
module clpt_timer (
  input wire logic clk,
  input wire logic rst,
  input clpt_pkg::clpt_tcfg_type cfg,
  input wire logic src_tick,
  input wire logic event_tick,
  input wire logic reload_we,
  input wire logic [15:0] reload_data,
  output logic [15:0] count,
  output logic [15:0] reload,
  output logic underflow,
  output logic out_pin
);
  import clpt_pkg::*;

  logic [15:0] reload_reg;   // reload value
  logic [15:0] count_reg;    // live counter
  logic uf_reg;              // underflow pulse
  logic toggle_reg;          // output toggle state
  // mode picks the step: own source or upstream event
  wire step = cfg.start & (cfg.event_mode ? event_tick : src_tick);
  wire at_zero = (count_reg == 16'h0000);

  // counting, reload and output toggle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reload_reg <= `CLPT_RST_RELOAD;
      count_reg <= `CLPT_RST_RELOAD;
      uf_reg <= 1'b0;
      toggle_reg <= 1'b0;
    end else begin
      uf_reg <= step & at_zero;
      if (reload_we) begin
        reload_reg <= reload_data;
      end
      if (!cfg.start) begin
        toggle_reg <= 1'b0;             // stopped pin rests at idle level
        if (reload_we) begin
          count_reg <= reload_data;     // a stopped timer takes the new value at once
        end
      end else if (step) begin
        if (at_zero) begin
          count_reg <= reload_reg;      // reload and keep counting
          toggle_reg <= ~toggle_reg;
        end else begin
          count_reg <= count_reg - 16'h0001;  // one count per tick
        end
      end
    end
  end

  assign count = count_reg;
  assign reload = reload_reg;
  assign underflow = uf_reg;
  assign out_pin = toggle_reg ^ cfg.polarity;
endmodule : clpt_timer

//--- core/clpt_top.sv
// Purpose: two chained 16-bit timers forming a long-period timer, APB slave
// Assumes: all inputs synchronous to CLK, APB master per the protocol
// Notes: one wait state on every access, unmapped addresses answer with an error
`timescale 1ns/100ps
`include "clpt_defines.svh"
module clpt_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SUB_CLK,
  input wire logic LOCO,
  input wire logic EVENT_IN,
  output logic IRQ,
  output logic TIMER0_OUT,
  output logic TIMER1_OUT
);
  import clpt_pkg::*;

  // ---------------------------------------------------------------
  // count source selection, shared by both timers
  // ---------------------------------------------------------------

  // picks one tick from the extended or legacy select fields
  function automatic logic pick_source(
    input logic [3:0] ext,
    input logic [1:0] legacy,
    input logic base,
    input clpt_ticks_type t
  );
    logic r;
    r = 1'b0;
    // the extended field overrides the legacy one
    if (ext[`CLPT_EXT_ENABLE_BIT]) begin
      // extended select in force
      case (ext[2:0])
        3'b000: r = base;
        3'b001: r = t.div8;
        3'b010: r = t.div32;
        3'b011: r = t.div64;
        3'b101: r = t.oco;
        3'b110: r = t.sub32;
        default: r = 1'b0;  // reserved codes give no ticks
      endcase
    end else begin
      // legacy two-bit select
      case (legacy)
        2'b00: r = base;
        2'b01: r = t.div8;
        2'b10: r = t.div32;
        2'b11: r = t.sub32;
        default: r = 1'b0;
      endcase
    end
    // the caller folds the clock-select choice into base
    return r;
  endfunction : pick_source

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  // each control next value is a continuous assignment below; the bus next values come from the always_comb block
  logic [1:0] start_reg;          // timer_count_start_flag per timer
  logic [1:0] start_next;
  logic [7:0] mode0_reg;          // timer_mode_register of timer 0
  logic [7:0] mode0_next;
  logic [7:0] mode1_reg;          // timer_mode_register of timer 1
  logic [7:0] mode1_next;
  logic [7:0] extsel_reg;         // extended_source_select_reg
  logic [7:0] extsel_next;
  logic pclk_reg;                 // peripheral_clock_halve_select
  logic pclk_next;
  logic [1:0] pol_reg;            // output_polarity_register
  logic [1:0] pol_next;
  logic [1:0] flags_reg;          // sticky interrupt request flags
  logic [1:0] flags_next;
  logic [1:0] mask_reg;           // interrupt enables
  logic [1:0] mask_next;
  logic irq_reg;                  // registered interrupt line
  logic irq_next;

  // bus slave state
  clpt_bus_state_type bus_state_reg;
  clpt_bus_state_type bus_state_next;
  logic [31:0] rdata_reg;         // read data held during the ready cycle
  logic [31:0] rdata_next;
  logic pready_reg;               // ready pulse
  logic pready_next;
  logic pslverr_reg;              // error flag with ready
  logic pslverr_next;

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  clpt_ticks_type ticks;          // all candidate count sources
  clpt_tcfg_type cfg0;            // settings for timer 0
  clpt_tcfg_type cfg1;            // settings for timer 1
  logic [15:0] count0;            // timer 0 live count
  logic [15:0] count1;            // timer 1 live count
  // reload values come back through the timer ports
  logic [15:0] reload0;           // timer 0 reload value
  logic [15:0] reload1;           // timer 1 reload value
  logic uf0;                      // timer 0 underflow pulse
  logic uf1;                      // timer 1 underflow pulse
  logic pin0;                     // timer 0 pin level
  logic pin1;                     // timer 1 pin level

  clpt_prescaler u_prescaler (
    .clk(CLK),
    .rst(RST),
    .sub_clk(SUB_CLK),
    .loco(LOCO),
    .ticks(ticks)
  );

  // base source is undivided or halved by the clock select bit
  wire base_tick = pclk_reg ? ticks.undiv : ticks.half;

  // each timer takes its own nibble of the extended register
  wire src0 = pick_source(extsel_reg[`CLPT_EXT_T0_HI:`CLPT_EXT_T0_LO],
                          mode0_reg[`CLPT_MODE_SRC_HI:`CLPT_MODE_SRC_LO], base_tick, ticks);
  wire src1 = pick_source(extsel_reg[`CLPT_EXT_T1_HI:`CLPT_EXT_T1_LO],
                          mode1_reg[`CLPT_MODE_SRC_HI:`CLPT_MODE_SRC_LO], base_tick, ticks);

  // settings of each timer travel in one carrier
  assign cfg0.start = start_reg[0];
  assign cfg0.event_mode = mode0_reg[`CLPT_MODE_EVENT_BIT];
  assign cfg0.polarity = pol_reg[0];
  assign cfg1.start = start_reg[1];
  assign cfg1.event_mode = mode1_reg[`CLPT_MODE_EVENT_BIT];
  assign cfg1.polarity = pol_reg[1];

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------

  // the access phase is seen first in IDLE, the write lands in ACK
  wire access = PSEL & PENABLE;
  wire in_ack = (bus_state_reg == CLPT_BUS_ACK);
  wire wr_commit = access & in_ack & PWRITE;
  // full-byte compare: misaligned offsets hit nothing
  wire hit_ctrl = (PADDR == `CLPT_OFF_CTRL);
  wire hit_mode0 = (PADDR == `CLPT_OFF_MODE0);
  wire hit_mode1 = (PADDR == `CLPT_OFF_MODE1);
  wire hit_reload0 = (PADDR == `CLPT_OFF_RELOAD0);
  wire hit_reload1 = (PADDR == `CLPT_OFF_RELOAD1);
  wire hit_count0 = (PADDR == `CLPT_OFF_COUNT0);
  wire hit_count1 = (PADDR == `CLPT_OFF_COUNT1);
  wire hit_extsel = (PADDR == `CLPT_OFF_EXTSEL);
  wire hit_pclk = (PADDR == `CLPT_OFF_PCLK);
  wire hit_pol = (PADDR == `CLPT_OFF_POL);
  wire hit_status = (PADDR == `CLPT_OFF_STATUS);
  wire hit_mask = (PADDR == `CLPT_OFF_MASK);
  // no hit refuses the access with an error
  wire hit_any = hit_ctrl | hit_mode0 | hit_mode1 | hit_reload0 | hit_reload1 | hit_count0 |
                 hit_count1 | hit_extsel | hit_pclk | hit_pol | hit_status | hit_mask;

  // reload writes go straight to the timers
  wire reload0_we = wr_commit & hit_reload0;
  wire reload1_we = wr_commit & hit_reload1;

  // timer 0 in event mode counts the external event input
  clpt_timer u_timer0 (
    .clk(CLK),
    .rst(RST),
    .cfg(cfg0),
    .src_tick(src0),
    .event_tick(EVENT_IN),
    .reload_we(reload0_we),
    .reload_data(PWDATA[15:0]),
    .count(count0),
    .reload(reload0),
    .underflow(uf0),
    .out_pin(pin0)
  );

  // timer 1 in event mode counts timer 0 underflows, forming the chain
  clpt_timer u_timer1 (
    .clk(CLK),
    .rst(RST),
    .cfg(cfg1),
    .src_tick(src1),
    .event_tick(uf0),
    .reload_we(reload1_we),
    .reload_data(PWDATA[15:0]),
    .count(count1),
    .reload(reload1),
    .underflow(uf1),
    .out_pin(pin1)
  );

  // ---------------------------------------------------------------
  // register next values
  // ---------------------------------------------------------------

  // start flags: a zero stops the timer and holds its count, except that a reload write loads the new value
  assign start_next = (wr_commit & hit_ctrl) ? PWDATA[1:0] : start_reg;
  // other registers take the written bits as they stand
  assign mode0_next = (wr_commit & hit_mode0) ? PWDATA[7:0] : mode0_reg;
  assign mode1_next = (wr_commit & hit_mode1) ? PWDATA[7:0] : mode1_reg;
  assign extsel_next = (wr_commit & hit_extsel) ? PWDATA[7:0] : extsel_reg;
  assign pclk_next = (wr_commit & hit_pclk) ? PWDATA[0] : pclk_reg;
  assign pol_next = (wr_commit & hit_pol) ? PWDATA[1:0] : pol_reg;
  assign mask_next = (wr_commit & hit_mask) ? PWDATA[1:0] : mask_reg;

  // underflows set flags; a set in the clear cycle survives
  wire [1:0] flag_set = {uf1, uf0};
  // a clear acts only on bits written as one
  wire [1:0] flag_clr = (wr_commit & hit_status) ? PWDATA[1:0] : 2'b00;
  assign flags_next = (flags_reg & ~flag_clr) | flag_set;

  // level interrupt from any unmasked pending flag
  assign irq_next = |(flags_next & mask_reg);

  // read multiplexer, unused upper bits read zero
  wire [31:0] rd_mux = hit_ctrl ? {30'h0, start_reg} :
                       hit_mode0 ? {24'h0, mode0_reg} :
                       hit_mode1 ? {24'h0, mode1_reg} :
                       hit_reload0 ? {16'h0, reload0} :
                       hit_reload1 ? {16'h0, reload1} :
                       hit_count0 ? {16'h0, count0} :
                       hit_count1 ? {16'h0, count1} :
                       hit_extsel ? {24'h0, extsel_reg} :
                       hit_pclk ? {31'h0, pclk_reg} :
                       hit_pol ? {30'h0, pol_reg} :
                       hit_status ? {30'h0, flags_reg} :
                       hit_mask ? {30'h0, mask_reg} : 32'h0000_0000;

  // ---------------------------------------------------------------
  // bus sequencing
  // ---------------------------------------------------------------

  // one wait state keeps every bus output coming from a flop
  always_comb begin
    bus_state_next = bus_state_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    rdata_next = rdata_reg;
    case (bus_state_reg)
      CLPT_BUS_IDLE: begin
        // only the first access cycle starts an answer
        if (access) begin
          bus_state_next = CLPT_BUS_ACK;
          pready_next = 1'b1;
          pslverr_next = ~hit_any;                     // unmapped address answers an error
          rdata_next = PWRITE ? 32'h0000_0000 : rd_mux; // sampled before the ready edge
        end
      end
      CLPT_BUS_ACK: begin
        bus_state_next = CLPT_BUS_IDLE;                // master drops the access next
        // read bus drops back to zero after ready
        rdata_next = 32'h0000_0000;
      end
      default: begin
        // an illegal code recovers to idle
        bus_state_next = CLPT_BUS_IDLE;
      end
    endcase
  end

  // bus state and answer flops
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bus_state_reg <= CLPT_BUS_IDLE;
      rdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      bus_state_reg <= bus_state_next;
      rdata_reg <= rdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // software-visible control registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      start_reg <= `CLPT_RST_CTRL;
      mode0_reg <= `CLPT_RST_MODE;
      mode1_reg <= `CLPT_RST_MODE;
      extsel_reg <= `CLPT_RST_EXTSEL;
      pclk_reg <= `CLPT_RST_PCLK;
      pol_reg <= `CLPT_RST_POL;
      mask_reg <= `CLPT_RST_FLAGS;
    end else begin
      // unchanged registers simply recirculate
      start_reg <= start_next;
      mode0_reg <= mode0_next;
      mode1_reg <= mode1_next;
      extsel_reg <= extsel_next;
      pclk_reg <= pclk_next;
      pol_reg <= pol_next;
      mask_reg <= mask_next;
    end
  end

  // interrupt flags, line and pins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flags_reg <= `CLPT_RST_FLAGS;
      irq_reg <= 1'b0;
      TIMER0_OUT <= 1'b0;
      TIMER1_OUT <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      irq_reg <= irq_next;
      // pins are re-timed so each comes from a flop
      TIMER0_OUT <= pin0;   // low while stopped and non-inverted
      TIMER1_OUT <= pin1;
    end
  end

  // outputs are plain copies of flops
  assign PRDATA = rdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign IRQ = irq_reg;
endmodule : clpt_top

//--- tb/clpt_checker.sv
// Purpose: port-level checks of the cascaded long-period timer
// Assumes: the master keeps the APB setup and access sequence
// Notes: CTRL, POL and MASK are shadowed from accepted writes
`timescale 1ns/100ps
`include "clpt_defines.svh"
module clpt_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ,
  input wire logic TIMER0_OUT,
  input wire logic TIMER1_OUT
);
  logic [1:0] ctrl_reg;  // shadow of the start flags
  logic [1:0] pol_reg;  // shadow of the polarity bits
  logic [1:0] mask_reg;  // shadow of the interrupt mask
  logic [2:0] quiet_reg;  // cycles with both timers stopped and no write
  // a write lands at the edge where ready is sampled high without error
  wire wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  wire acc = PSEL && PENABLE && PREADY;
  wire unmapped = (PADDR > `CLPT_OFF_MASK) || (PADDR[1:0] != 2'h0);
  wire stop0 = !ctrl_reg[0] && !pol_reg[0];
  wire stop1 = !ctrl_reg[1] && !pol_reg[1];

  // shadows update on the same edge as the design's registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= 2'h0;
      pol_reg <= 2'h0;
      mask_reg <= 2'h0;
    end else if (wr_ok) begin
      if (PADDR == `CLPT_OFF_CTRL) ctrl_reg <= PWDATA[1:0];
      if (PADDR == `CLPT_OFF_POL) pol_reg <= PWDATA[1:0];
      if (PADDR == `CLPT_OFF_MASK) mask_reg <= PWDATA[1:0];
    end
  end

  // any write may clear flags or open the mask, so it restarts the count
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      quiet_reg <= 3'h0;
    end else if (wr_ok || ctrl_reg != 2'h0) begin
      quiet_reg <= 3'h0;
    end else if (quiet_reg != 3'h7) begin
      quiet_reg <= quiet_reg + 3'h1;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  a_one_wait_state: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready did not follow the first access cycle");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error answer without ready");
  a_unmapped_err: assert property (acc && unmapped |-> PSLVERR)
    else $error("unmapped access answered without error");
  a_mapped_no_err: assert property (acc && !unmapped |-> !PSLVERR)
    else $error("mapped access answered with error");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data not zero outside ready");
  a_pin0_stopped: assert property (stop0 [*4] |-> !TIMER0_OUT)
    else $error("stopped timer0 pin not low");
  a_pin1_stopped: assert property (stop1 [*4] |-> !TIMER1_OUT)
    else $error("stopped timer1 pin not low");
  a_stopped_no_irq: assert property (quiet_reg >= 3'h4 |-> !$rose(IRQ))
    else $error("interrupt rose while both timers stopped");
  a_mask_closed: assert property (mask_reg == 2'h0 && $past(mask_reg) == 2'h0 |-> !IRQ)
    else $error("interrupt high with mask closed");

  c_chain_start: cover property (wr_ok && PADDR == `CLPT_OFF_CTRL && PWDATA[1:0] == 2'h3);
  c_irq_rise: cover property ($rose(IRQ));
  c_refused: cover property (PSLVERR);
endmodule : clpt_checker

bind clpt_top clpt_checker i_clpt_checker (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .IRQ(IRQ), .TIMER0_OUT(TIMER0_OUT), .TIMER1_OUT(TIMER1_OUT));

//--- tb/test_cascaded_long_period_timer.sv
// Purpose: directed bench for the cascaded long-period timer
// Assumes: pins toggle on underflow
// Notes: slow inputs come from a free counter so each source has its own period
`timescale 1ns/100ps
`include "clpt_defines.svh"
module test_cascaded_long_period_timer;
  logic CLK, RST, PSEL, PENABLE, PWRITE, SUB_CLK, LOCO, EVENT_IN;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdv;
  logic PREADY, PSLVERR, IRQ, TIMER0_OUT, TIMER1_OUT, errv;
  logic [3:0] div_reg;  // free counter for the slow inputs
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  clpt_top i_clpt_top (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SUB_CLK(SUB_CLK), .LOCO(LOCO), .EVENT_IN(EVENT_IN), .IRQ(IRQ),
    .TIMER0_OUT(TIMER0_OUT), .TIMER1_OUT(TIMER1_OUT));

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // sub-clock rises every 8 cycles, oscillator every 16, events come in pairs every 8
  always @(posedge CLK) begin
    div_reg <= div_reg + 4'h1;
    SUB_CLK <= div_reg[2];
    LOCO <= div_reg[3];
    EVENT_IN <= div_reg[2] & div_reg[1];
  end

  // a hang counts as a mismatch and ends the run
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check_word

  task automatic check_gap(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      n_errors++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_gap

  // one APB transfer; ready, data and error are read at a rising edge, before its updates
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= addr;
    PWDATA <= wdata;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 20) begin
      n++;
      @(posedge CLK);
    end
    check_word("ready", 32'h1, 32'(PREADY));
    rdv = PRDATA;
    errv = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  function automatic logic pin(input bit sel);
    return sel ? TIMER1_OUT : TIMER0_OUT;
  endfunction : pin

  // the first toggle has an unknown prescaler phase, so the gap to the second is counted
  task automatic measure_gap(input bit sel, output int gap);
    logic last;
    int n;
    gap = 0;
    n = 0;
    @(negedge CLK);
    last = pin(sel);
    while (pin(sel) === last && n < 2000) begin
      n++;
      @(negedge CLK);
    end
    last = pin(sel);
    while (pin(sel) === last && gap < 2000) begin
      gap++;
      @(negedge CLK);
    end
  endtask : measure_gap

  task automatic t_reset_vals();
    logic [31:0] exp [12];
    exp = '{0, 0, 0, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 0, 0, 0, 0, 0};
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check_word("reset value", exp[i], rdv);
    end
    apb(1'b1, `CLPT_OFF_COUNT0, 32'h1234);
    apb(1'b0, `CLPT_OFF_COUNT0, 32'h0);
    check_word("count after write", 32'hFFFF, rdv);
    apb(1'b0, 8'h30, 32'h0);
    check_word("unmapped error", 32'h1, 32'(errv));
    check_word("unmapped data", 32'h0, rdv);
    $display("test reset values done");
  endtask : t_reset_vals

  task automatic t_sources();
    // {clock select, mode0, extended select} and the pin gap with reload 1
    logic [23:0] cfg [13];
    int gaps [13];
    int gap;
    cfg = '{24'h010000, 24'h000000, 24'h014000, 24'h018000, 24'h01C000, 24'h010008, 24'h010009,
      24'h01000A, 24'h01000B, 24'h01000D, 24'h01000E, 24'h01C009, 24'h010100};
    gaps = '{2, 4, 16, 64, 512, 2, 16, 64, 128, 32, 512, 16, 8};
    for (int i = 0; i < 13; i++) begin
      apb(1'b1, `CLPT_OFF_CTRL, 32'h0);
      apb(1'b1, `CLPT_OFF_PCLK, {24'h0, cfg[i][23:16]});
      apb(1'b1, `CLPT_OFF_MODE0, {24'h0, cfg[i][15:8]});
      apb(1'b1, `CLPT_OFF_EXTSEL, {24'h0, cfg[i][7:0]});
      apb(1'b1, `CLPT_OFF_RELOAD0, 32'h1);
      apb(1'b1, `CLPT_OFF_CTRL, 32'h1);
      measure_gap(1'b0, gap);
      check_gap("timer0 gap", gaps[i], gap);
    end
    $display("test count sources done");
  endtask : t_sources

  task automatic t_chain();
    int gap;
    logic [31:0] held;
    apb(1'b1, `CLPT_OFF_CTRL, 32'h0);
    apb(1'b1, `CLPT_OFF_STATUS, 32'h3);  // flags left by earlier tests
    apb(1'b1, `CLPT_OFF_PCLK, 32'h1);
    apb(1'b1, `CLPT_OFF_MODE0, 32'h0);
    apb(1'b1, `CLPT_OFF_MODE1, 32'h1);
    apb(1'b1, `CLPT_OFF_EXTSEL, 32'h0);
    apb(1'b1, `CLPT_OFF_RELOAD0, 32'h3);
    apb(1'b1, `CLPT_OFF_RELOAD1, 32'h2);
    apb(1'b1, `CLPT_OFF_CTRL, 32'h3);
    measure_gap(1'b0, gap);
    check_gap("timer0 gap", 4, gap);
    measure_gap(1'b1, gap);
    check_gap("timer1 gap", 12, gap);
    apb(1'b0, `CLPT_OFF_STATUS, 32'h0);
    check_word("status", 32'h3, rdv);
    check_word("masked irq", 32'h0, 32'(IRQ));
    apb(1'b1, `CLPT_OFF_MASK, 32'h2);
    repeat (2) @(negedge CLK);
    check_word("open irq", 32'h1, 32'(IRQ));
    apb(1'b1, `CLPT_OFF_CTRL, 32'h0);
    apb(1'b1, `CLPT_OFF_STATUS, 32'h3);
    apb(1'b0, `CLPT_OFF_COUNT0, 32'h0);
    held = rdv;
    repeat (20) @(posedge CLK);
    apb(1'b0, `CLPT_OFF_COUNT0, 32'h0);
    check_word("held count", held, rdv);
    apb(1'b0, `CLPT_OFF_STATUS, 32'h0);
    check_word("stopped status", 32'h0, rdv);
    check_word("cleared irq", 32'h0, 32'(IRQ));
    check_word("stopped pins", 32'h0, {30'h0, TIMER1_OUT, TIMER0_OUT});
    apb(1'b1, `CLPT_OFF_POL, 32'h3);
    repeat (3) @(negedge CLK);
    check_word("inverted pins", 32'h3, {30'h0, TIMER1_OUT, TIMER0_OUT});
    apb(1'b1, `CLPT_OFF_POL, 32'h0);
    $display("test chained timers done");
  endtask : t_chain

  task automatic t_timer1_ext();
    int gap;
    apb(1'b1, `CLPT_OFF_MODE1, 32'h0);
    apb(1'b1, `CLPT_OFF_EXTSEL, 32'h90);
    apb(1'b1, `CLPT_OFF_RELOAD1, 32'h1);
    apb(1'b1, `CLPT_OFF_CTRL, 32'h2);
    measure_gap(1'b1, gap);
    check_gap("timer1 divide-by-8 gap", 16, gap);
    apb(1'b0, `CLPT_OFF_EXTSEL, 32'h0);
    check_word("extended select", 32'h90, rdv);
    $display("test second timer source done");
  endtask : t_timer1_ext

  initial begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    SUB_CLK = 1'b0;
    LOCO = 1'b0;
    EVENT_IN = 1'b0;
    div_reg = 4'h0;
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    t_reset_vals();
    t_sources();
    t_chain();
    t_timer1_ext();
    report_and_stop();
  end
endmodule : test_cascaded_long_period_timer
